/* File: cmb_mailbox.sv */
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "cmb_regs.svh"
module cmb_mailbox #(
  parameter int NMB = 32
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bit_tick,
  input wire logic crc_field_p,
  input wire logic err_delim_p,
  input wire logic intermission_p,
  input wire logic bus_idle,
  input wire logic bus_off,
  input wire logic eof6_p,
  input wire logic proto_err,
  input wire cmb_pkg::cmb_frame_s rx_frame,
  input wire logic tx_done_p,
  output cmb_pkg::cmb_frame_s tx_frame,
  output logic tx_pending,
  output logic mb_irq
);
  import cmb_pkg::*;

  localparam int IW = $clog2(NMB);
  localparam logic [IW-1:0] LAST = IW'(NMB - 1);
  localparam logic [31:0] VMASK = 32'((64'h1 << NMB) - 64'h1);

  // Mailbox storage
  cmb_cs_s cs_q [NMB];
  logic [28:0] id_q [NMB];
  logic [31:0] d0_q [NMB];
  logic [31:0] d1_q [NMB];
  // Software registers
  logic [31:0] ctrl_q, ien_q, mailbox_interrupt_flags_q;
  logic [28:0] rxmask_q;
  logic [15:0] timer_q;
  logic frz_prev_q;
  // Bus handshake
  logic wait_q;
  logic [31:0] rdata_q, rd_d;
  // Arbitration scanner
  cmb_scan_e arb_st_q;
  logic [IW-1:0] arb_idx_q, best_n_q;
  logic best_v_q, need_q;
  logic [31:0] best_key_q;
  logic [NMB-1:0] arb_deact_q;
  // Serial buffer for transmit
  cmb_frame_s tx_frame_q;
  logic tx_pend_q, mo_deact_q;
  logic [IW-1:0] tx_n_q;
  // Matching scanner and serial buffer for receive
  cmb_scan_e mt_st_q;
  logic [IW-1:0] mt_idx_q, mt_n_q;
  logic mt_hit_q;
  logic [NMB-1:0] mt_deact_q;
  cmb_frame_s rx_smb_q;
  // Lock and move-in
  logic lock_v_q, pend_q, mi_busy_q, irq_q;
  logic [IW-1:0] lock_n_q, pend_n_q, mi_n_q;
  logic [NMB-1:0] serviced_q;

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = be[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
  endfunction

  // Priority key, RTR and IDE where the frame carries them
  function automatic logic [31:0] arb_key(input logic [28:0] id, input logic ide,
                                          input logic rtr);
    arb_key = ide ? {id[28:18], 1'b1, 1'b1, id[17:0], rtr}
                  : {id[28:18], rtr, 1'b0, 19'h00000};
  endfunction

  // Address decode
  logic [11:0] mb_off;
  logic [IW-1:0] mb_n;
  logic [1:0] mb_fld;
  logic in_mb, acc, rd_acc, wr_acc, cs_rd, cs_wr, cs_wr_act, tmr_rd;
  logic [31:0] wmerge, clr;
  cmb_code_t sel_code;
  assign mb_off = avs_address - `CMB_MB_BASE;
  assign mb_n = mb_off[4 +: IW];
  assign mb_fld = mb_off[3:2];
  assign in_mb = (avs_address >= `CMB_MB_BASE) && (32'(mb_off) < NMB * `CMB_MB_STRIDE);
  assign acc = (avs_read || avs_write) && !wait_q;
  assign rd_acc = acc && avs_read;
  assign wr_acc = acc && avs_write;
  assign cs_rd = rd_acc && in_mb && (mb_fld == 2'd0);
  assign cs_wr = wr_acc && in_mb && (mb_fld == 2'd0);
  assign sel_code = cs_q[mb_n].code;
  // Write to a mailbox holding an active code
  assign cs_wr_act = cs_wr && (sel_code != CODE_RX_OFF) && (sel_code != CODE_TX_OFF);
  assign tmr_rd = rd_acc && (avs_address == `CMB_TIMER_OFS);
  assign wmerge = merge(32'h00000000, avs_writedata, avs_byteenable);
  assign clr = (wr_acc && avs_address == `CMB_MAILBOX_INTERRUPT_FLAGS_OFS) ? wmerge : 32'h00000000;

  // Read mux; busy shows during move-in
  always_comb begin
    cmb_cs_s c;
    c = cs_q[mb_n];
    rd_d = 32'h00000000;
    if (mi_busy_q && mi_n_q == mb_n) begin
      c.code = c.code | CODE_BUSY;
    end
    if (in_mb) begin
      unique case (mb_fld)
        2'd0: rd_d = 32'(c);
        2'd1: rd_d = {3'h0, id_q[mb_n]};
        2'd2: rd_d = d0_q[mb_n];
        default: rd_d = d1_q[mb_n];
      endcase
    end else begin
      unique case (avs_address)
        `CMB_CTRL_OFS: rd_d = ctrl_q;
        `CMB_TIMER_OFS: rd_d = {16'h0000, timer_q};
        `CMB_RXMASK_OFS: rd_d = {3'h0, rxmask_q};
        `CMB_STAT_OFS: rd_d = {16'h0000, tx_pend_q, need_q, lock_v_q, pend_q, 2'b00,
                               5'(lock_n_q), 5'(tx_n_q)};
        `CMB_IEN_OFS: rd_d = ien_q;
        `CMB_MAILBOX_INTERRUPT_FLAGS_OFS: rd_d = mailbox_interrupt_flags_q;
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  // Bus slave: one wait state, then answer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
      rdata_q <= rd_d;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Control, enable, mask and free-running timer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q <= `CMB_CTRL_RST;
      ien_q <= `CMB_IEN_RST;
      rxmask_q <= `CMB_RXMASK_RST;
      timer_q <= `CMB_TIMER_RST;
      frz_prev_q <= 1'b0;
    end else begin
      frz_prev_q <= ctrl_q[`CMB_CTRL_FRZ_BIT];
      if (bit_tick) begin
        timer_q <= timer_q + 16'h0001;
      end
      if (wr_acc && avs_address == `CMB_CTRL_OFS) begin
        ctrl_q <= merge(ctrl_q, avs_writedata, avs_byteenable);
      end
      if (wr_acc && avs_address == `CMB_IEN_OFS) begin
        ien_q <= merge(ien_q, avs_writedata, avs_byteenable) & VMASK;
      end
      if (wr_acc && avs_address == `CMB_RXMASK_OFS) begin
        rxmask_q <= 29'(merge({3'h0, rxmask_q}, avs_writedata, avs_byteenable));
      end
    end
  end

  // Completion events per mailbox
  logic tx_ok, frz_q, frz_fall, arb_trig, arb_elig, mt_elig, mt_ok, rel_rd, mi_req;
  logic [IW-1:0] mi_src;
  logic [31:0] set_v;
  assign tx_ok = tx_done_p && tx_pend_q && !mo_deact_q;
  always_comb begin
    set_v = 32'h00000000;
    for (int i = 0; i < NMB; i++) begin
      set_v[i] = (tx_ok && tx_n_q == IW'(i)) || (mi_busy_q && mi_n_q == IW'(i));
    end
  end

  // Flags: set beats write-one clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mailbox_interrupt_flags_q <= `CMB_MAILBOX_INTERRUPT_FLAGS_RST;
    end else begin
      mailbox_interrupt_flags_q <= (mailbox_interrupt_flags_q & ~clr) | set_v;
    end
  end

  // Interrupt request from flag and enable
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(mailbox_interrupt_flags_q & ien_q);
    end
  end

  // Arbitration triggers
  assign frz_q = ctrl_q[`CMB_CTRL_FRZ_BIT];
  assign frz_fall = frz_prev_q && !frz_q;
  assign arb_trig = !frz_q && (crc_field_p || err_delim_p || (intermission_p && need_q) ||
                    ((bus_idle || bus_off) && cs_wr) || frz_fall);
  // Active transmit mailbox not dropped this round
  assign arb_elig = cs_q[arb_idx_q].code[3] && (cs_q[arb_idx_q].code != CODE_TX_OFF) &&
                    !arb_deact_q[arb_idx_q] && !(cs_wr && mb_n == arb_idx_q) &&
                    !(tx_pend_q && tx_n_q == arb_idx_q);

  // Arbitration scan, one mailbox per cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      arb_st_q <= SC_IDLE;
      arb_idx_q <= '0;
      best_v_q <= 1'b0;
      best_n_q <= '0;
      best_key_q <= 32'h00000000;
      need_q <= 1'b0;
    end else begin
      unique case (arb_st_q)
        SC_IDLE: begin
          if (arb_trig) begin
            arb_st_q <= SC_SCAN;
            arb_idx_q <= '0;
            best_v_q <= 1'b0;
            need_q <= 1'b0;
          end else if (cs_wr) begin
            need_q <= 1'b1;
          end
        end
        SC_SCAN: begin
          // Ascending scan: first hit is lowest number
          if (arb_elig && (!best_v_q || (!ctrl_q[`CMB_CTRL_LBF_BIT] &&
              arb_key(id_q[arb_idx_q], cs_q[arb_idx_q].ide, cs_q[arb_idx_q].rtr) <
              best_key_q))) begin
            best_v_q <= 1'b1;
            best_n_q <= arb_idx_q;
            best_key_q <= arb_key(id_q[arb_idx_q], cs_q[arb_idx_q].ide, cs_q[arb_idx_q].rtr);
          end else if (cs_wr && best_v_q && mb_n == best_n_q) begin
            best_v_q <= 1'b0;
          end
          if (arb_idx_q == LAST) begin
            arb_st_q <= SC_DONE;
          end else begin
            arb_idx_q <= arb_idx_q + 1'b1;
          end
        end
        SC_DONE: begin
          arb_st_q <= SC_IDLE;
          need_q <= best_v_q && (tx_pend_q || (cs_wr && mb_n == best_n_q));
        end
      endcase
    end
  end

  // Mailboxes dropped from the current rounds
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      arb_deact_q <= '0;
      mt_deact_q <= '0;
    end else begin
      for (int i = 0; i < NMB; i++) begin
        arb_deact_q[i] <= (arb_st_q == SC_IDLE && arb_trig) ? 1'b0 :
                          (arb_deact_q[i] || (cs_wr_act && mb_n == IW'(i)));
        mt_deact_q[i] <= crc_field_p ? 1'b0 :
                         (mt_deact_q[i] || (cs_wr_act && mb_n == IW'(i)));
      end
    end
  end

  // Move-out into the serial buffer and transmit hand-off
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_frame_q <= '0;
      tx_pend_q <= 1'b0;
      mo_deact_q <= 1'b0;
      tx_n_q <= '0;
    end else if (arb_st_q == SC_DONE && best_v_q && !tx_pend_q &&
                 !(cs_wr && mb_n == best_n_q)) begin
      tx_frame_q.id <= id_q[best_n_q];
      tx_frame_q.ide <= cs_q[best_n_q].ide;
      tx_frame_q.rtr <= cs_q[best_n_q].rtr;
      tx_frame_q.len <= cs_q[best_n_q].len;
      tx_frame_q.nbytes <= (cs_q[best_n_q].len > `CMB_MAX_BYTES) ?
                           `CMB_MAX_BYTES : cs_q[best_n_q].len;
      tx_frame_q.data <= {d0_q[best_n_q], d1_q[best_n_q]};
      tx_pend_q <= 1'b1;
      mo_deact_q <= 1'b0;
      tx_n_q <= best_n_q;
    end else begin
      if (tx_done_p) begin
        tx_pend_q <= 1'b0;
      end
      // Written after move-out: still sent, no update
      if (cs_wr && tx_pend_q && mb_n == tx_n_q) begin
        mo_deact_q <= 1'b1;
      end
    end
  end

  // Receive candidate with acceptance mask
  logic [28:0] cmask;
  assign cmask = rx_smb_q.ide ? rxmask_q : {rxmask_q[28:18], 18'h00000};
  assign mt_elig = !cs_q[mt_idx_q].code[3] && (cs_q[mt_idx_q].code != CODE_RX_OFF) &&
                   !mt_deact_q[mt_idx_q] && !(cs_wr && mb_n == mt_idx_q) &&
                   (cs_q[mt_idx_q].ide == rx_smb_q.ide) &&
                   (((id_q[mt_idx_q] ^ rx_smb_q.id) & cmask) == 29'h0);

  // Matching scan during the CRC field
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mt_st_q <= SC_IDLE;
      mt_idx_q <= '0;
      mt_n_q <= '0;
      mt_hit_q <= 1'b0;
      rx_smb_q <= '0;
    end else if (crc_field_p) begin
      rx_smb_q <= rx_frame;
      mt_st_q <= SC_SCAN;
      mt_idx_q <= '0;
      mt_hit_q <= 1'b0;
    end else begin
      if (mt_st_q == SC_SCAN && mt_elig && !mt_hit_q) begin
        mt_hit_q <= 1'b1;
        mt_n_q <= mt_idx_q;
      end else if (cs_wr && mt_hit_q && mb_n == mt_n_q) begin
        mt_hit_q <= 1'b0;
      end
      unique case (mt_st_q)
        SC_IDLE: mt_st_q <= SC_IDLE;
        SC_SCAN: begin
          if (mt_idx_q == LAST) begin
            mt_st_q <= SC_DONE;
          end else begin
            mt_idx_q <= mt_idx_q + 1'b1;
          end
        end
        SC_DONE: mt_st_q <= eof6_p ? SC_IDLE : SC_DONE;
      endcase
    end
  end

  // Move-in decisions
  assign mt_ok = eof6_p && !proto_err && mt_st_q == SC_DONE && mt_hit_q;
  assign rel_rd = lock_v_q && (tmr_rd || (cs_rd && mb_n != lock_n_q));
  assign mi_req = (mt_ok && !(lock_v_q && lock_n_q == mt_n_q)) ||
                  (pend_q && rel_rd && lock_n_q == pend_n_q);
  assign mi_src = (pend_q && rel_rd && lock_n_q == pend_n_q) ? pend_n_q : mt_n_q;

  // Single lock, pending move-in, serviced marks
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lock_v_q <= 1'b0;
      lock_n_q <= '0;
      pend_q <= 1'b0;
      pend_n_q <= '0;
      mi_busy_q <= 1'b0;
      mi_n_q <= '0;
      serviced_q <= '0;
    end else begin
      mi_busy_q <= mi_req;
      mi_n_q <= mi_src;
      if (cs_rd) begin
        lock_v_q <= (sel_code == CODE_RX_FULL || sel_code == CODE_RX_OVR) &&
                    !(mi_busy_q && mi_n_q == mb_n);
        lock_n_q <= mb_n;
      end else if (tmr_rd || (cs_wr && mb_n == lock_n_q)) begin
        lock_v_q <= 1'b0;
      end
      if (mt_ok && lock_v_q && lock_n_q == mt_n_q) begin
        pend_q <= 1'b1;
        pend_n_q <= mt_n_q;
      end else if ((pend_q && rel_rd && lock_n_q == pend_n_q) ||
                   (cs_wr && mb_n == pend_n_q)) begin
        pend_q <= 1'b0;
      end
      for (int i = 0; i < NMB; i++) begin
        if (mi_busy_q && mi_n_q == IW'(i)) begin
          serviced_q[i] <= 1'b0;
        end else if (rel_rd && lock_n_q == IW'(i)) begin
          serviced_q[i] <= 1'b1;
        end
      end
    end
  end

  // Mailbox memory: bus writes, move-in, transmit completion
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NMB; i++) begin
        cs_q[i] <= '0;
        id_q[i] <= 29'h0;
        d0_q[i] <= 32'h00000000;
        d1_q[i] <= 32'h00000000;
      end
    end else begin
      if (tx_ok) begin
        cs_q[tx_n_q].stamp <= timer_q;
        cs_q[tx_n_q].code <= CODE_TX_OFF;
      end
      if (mi_busy_q) begin
        cs_q[mi_n_q].stamp <= timer_q;
        cs_q[mi_n_q].ide <= rx_smb_q.ide;
        cs_q[mi_n_q].rtr <= rx_smb_q.rtr;
        cs_q[mi_n_q].len <= rx_smb_q.len;
        // Serviced or empty becomes full, else overrun
        cs_q[mi_n_q].code <= (cs_q[mi_n_q].code == CODE_RX_EMPTY || serviced_q[mi_n_q]) ?
                             CODE_RX_FULL : CODE_RX_OVR;
        id_q[mi_n_q] <= rx_smb_q.id;
        d0_q[mi_n_q] <= rx_smb_q.data[63:32];
        d1_q[mi_n_q] <= rx_smb_q.data[31:0];
      end
      if (wr_acc && in_mb) begin
        unique case (mb_fld)
          2'd0: cs_q[mb_n] <= cmb_cs_s'(merge(32'(cs_q[mb_n]), avs_writedata,
                                             avs_byteenable) & `CMB_CS_WMASK);
          2'd1: id_q[mb_n] <= 29'(merge({3'h0, id_q[mb_n]}, avs_writedata, avs_byteenable));
          2'd2: d0_q[mb_n] <= merge(d0_q[mb_n], avs_writedata, avs_byteenable);
          default: d1_q[mb_n] <= merge(d1_q[mb_n], avs_writedata, avs_byteenable);
        endcase
      end
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign tx_frame = tx_frame_q;
  assign tx_pending = tx_pend_q;
  assign mb_irq = irq_q;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_arb_go;
    arb_st_q == SC_IDLE && arb_trig;
  endsequence
  a_irq_follows_flag: assert property (##1 mb_irq == |$past(mailbox_interrupt_flags_q & ien_q))
    else $error("irq not flag and enable");
  a_irq_needs_enable: assert property (mb_irq |-> |$past(ien_q))
    else $error("irq without enable");
  a_flag_write_clear: assert property ((clr != 0) |=> ((mailbox_interrupt_flags_q & $past(clr & ~set_v)) == 0))
    else $error("flag not cleared");
  a_flag_set_wins: assert property ((set_v != 0) |=> ((mailbox_interrupt_flags_q & $past(set_v)) == $past(set_v)))
    else $error("set lost");
  a_tx_done_flag: assert property (tx_ok |=> mailbox_interrupt_flags_q[$past(tx_n_q)] &&
    cs_q[$past(tx_n_q)].code == CODE_TX_OFF) else $error("tx completion lost");
  a_arb_start: assert property (s_arb_go |=> arb_st_q == SC_SCAN && arb_idx_q == 0)
    else $error("arbitration not started");
  a_arb_inactive: assert property (arb_st_q == SC_DONE && best_v_q |->
    cs_q[best_n_q].code[3] && cs_q[best_n_q].code != CODE_TX_OFF)
    else $error("inactive mailbox won");
  a_byte_cap: assert property (tx_pending |-> tx_frame.nbytes <= `CMB_MAX_BYTES)
    else $error("more than eight bytes");
  a_lock_read: assert property (cs_rd && sel_code == CODE_RX_FULL && !mi_busy_q |=>
    lock_v_q && lock_n_q == $past(mb_n)) else $error("read did not lock");
  a_move_in: assert property (mi_busy_q |=> mailbox_interrupt_flags_q[$past(mi_n_q)] &&
    !cs_q[$past(mi_n_q)].code[3]) else $error("move-in incomplete");
  a_deact_mark: assert property (cs_wr_act && arb_st_q == SC_SCAN |=>
    arb_deact_q[$past(mb_n)]) else $error("deactivation missed");
endmodule

/* File: cmb_partner.sv */
`timescale 1ns/100ps
// Protocol engine side: bus events for foreign and own frames
module cmb_partner
  import cmb_pkg::*;
#(
  parameter int NMB = 4
) (
  input wire logic core_clk,
  input wire cmb_pkg::cmb_frame_s tx_frame,
  output logic bit_tick,
  output logic crc_field_p,
  output logic err_delim_p,
  output logic intermission_p,
  output logic bus_idle,
  output logic eof6_p,
  output logic proto_err,
  output cmb_pkg::cmb_frame_s rx_frame,
  output logic tx_done_p
);
  logic [1:0] tick_q; // Bit-time prescaler
  // Idle levels at time zero
  initial begin
    tick_q = 2'h0;
    bit_tick = 1'b0;
    crc_field_p = 1'b0;
    err_delim_p = 1'b0;
    intermission_p = 1'b0;
    bus_idle = 1'b1;
    eof6_p = 1'b0;
    proto_err = 1'b0;
    rx_frame = '0;
    tx_done_p = 1'b0;
  end
  // One bit time every four clocks
  always @(posedge core_clk) begin
    tick_q <= tick_q + 2'h1;
    bit_tick <= (tick_q == 2'h3);
  end
  // One frame on the wire; own frames are echoed back as received
  task automatic frame(input cmb_frame_s f, input logic own, input logic err);
    cmb_frame_s cur;
    cur = own ? tx_frame : f;
    @(posedge core_clk);
    bus_idle <= 1'b0;
    rx_frame <= cur;
    crc_field_p <= 1'b1;
    @(posedge core_clk);
    crc_field_p <= 1'b0;
    rx_frame <= ~cur; // Stale frame shown inverted once sampled
    repeat (NMB + 4) @(posedge core_clk); // Spacing keeps matching done
    eof6_p <= 1'b1;
    proto_err <= err;
    @(posedge core_clk);
    eof6_p <= 1'b0;
    proto_err <= 1'b0;
    tx_done_p <= own && !err; // Success reported only for clean own frames
    err_delim_p <= err; // Errored frame ends in an error delimiter
    @(posedge core_clk);
    tx_done_p <= 1'b0;
    err_delim_p <= 1'b0;
    bus_idle <= 1'b1;
  endtask
endmodule

/* File: cmb_pkg.sv */
package cmb_pkg;
  // Mailbox codes
  typedef logic [3:0] cmb_code_t;
  localparam cmb_code_t CODE_RX_OFF = 4'h0;
  localparam cmb_code_t CODE_RX_EMPTY = 4'h4;
  localparam cmb_code_t CODE_RX_FULL = 4'h2;
  localparam cmb_code_t CODE_RX_OVR = 4'h6;
  localparam cmb_code_t CODE_TX_OFF = 4'h8;
  localparam cmb_code_t CODE_BUSY = 4'h1;
  // Control/status word, laid out as the bus sees it
  typedef struct packed {
    logic [3:0] rsv_hi;
    cmb_code_t code;
    logic [1:0] rsv_lo;
    logic ide;
    logic rtr;
    logic [3:0] len;
    logic [15:0] stamp;
  } cmb_cs_s;
  // Frame between mailboxes and protocol engine
  typedef struct packed {
    logic [28:0] id;
    logic ide;
    logic rtr;
    logic [3:0] len;
    logic [3:0] nbytes;
    logic [63:0] data;
  } cmb_frame_s;
  // Scanner states, Gray from idle through scan to done
  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_SCAN = 2'b01,
    SC_DONE = 2'b11
  } cmb_scan_e;
endpackage

/* File: cmb_regs.svh */
`ifndef CMB_REGS_SVH
`define CMB_REGS_SVH
// Register byte offsets
`define CMB_CTRL_OFS 12'h000
`define CMB_TIMER_OFS 12'h008
`define CMB_RXMASK_OFS 12'h010
`define CMB_STAT_OFS 12'h018
`define CMB_IEN_OFS 12'h028
`define CMB_MAILBOX_INTERRUPT_FLAGS_OFS 12'h030
// Mailbox window: 16 bytes per mailbox
`define CMB_MB_BASE 12'h080
`define CMB_MB_STRIDE 16
// Control field positions
`define CMB_CTRL_FRZ_BIT 0
`define CMB_CTRL_LBF_BIT 4
// Writable bits of a control/status word
`define CMB_CS_WMASK 32'h0F3FFFFF
// Reset values
`define CMB_CTRL_RST 32'h00000000
`define CMB_IEN_RST 32'h00000000
`define CMB_MAILBOX_INTERRUPT_FLAGS_RST 32'h00000000
`define CMB_RXMASK_RST 29'h1FFFFFFF
`define CMB_TIMER_RST 16'h0000
// Most data bytes in one frame
`define CMB_MAX_BYTES 4'h8
`endif

/* File: test_cmb_mailbox.sv */
`timescale 1ns/100ps
`include "cmb_regs.svh"
module test_cmb_mailbox;
  import cmb_pkg::*;
  localparam int NMB = 4;
  localparam logic [28:0] ID_A = 29'h04000000; // Higher priority id
  localparam logic [28:0] ID_B = 29'h08000000;
  logic core_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic bit_tick, crc_field_p, err_delim_p, intermission_p, bus_idle, bus_off;
  logic eof6_p, proto_err, tx_done_p, tx_pending, mb_irq;
  cmb_frame_s rx_frame, tx_frame, f;
  int n_fail, tests_run, cycles;
  cmb_mailbox #(.NMB(NMB)) i_cmb_mailbox (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bit_tick(bit_tick),
    .crc_field_p(crc_field_p), .err_delim_p(err_delim_p), .intermission_p(intermission_p),
    .bus_idle(bus_idle), .bus_off(bus_off), .eof6_p(eof6_p), .proto_err(proto_err),
    .rx_frame(rx_frame), .tx_done_p(tx_done_p), .tx_frame(tx_frame),
    .tx_pending(tx_pending), .mb_irq(mb_irq));
  cmb_partner #(.NMB(NMB)) i_cmb_partner (.core_clk(core_clk), .tx_frame(tx_frame),
    .bit_tick(bit_tick), .crc_field_p(crc_field_p), .err_delim_p(err_delim_p),
    .intermission_p(intermission_p), .bus_idle(bus_idle), .eof6_p(eof6_p),
    .proto_err(proto_err), .rx_frame(rx_frame), .tx_done_p(tx_done_p));
  // Clock, 25 ns period
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      close_out();
    end
  end
  // Word compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // Sampled at the rising edge; the answer edge is also the release edge
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Read and compare under a mask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask
  // Mailbox word address
  function automatic logic [11:0] mb(input int n, input int w);
    return `CMB_MB_BASE + 12'(`CMB_MB_STRIDE * n + 4 * w);
  endfunction
  // Status word with code and length
  function automatic logic [31:0] cs(input logic [3:0] code, input logic [3:0] len);
    return {4'h0, code, 4'h0, len, 16'h0};
  endfunction
  // Main sequence
  initial begin
    {sys_rst, avs_address, avs_read, avs_write, avs_writedata} = {1'b1, 46'h0};
    avs_byteenable = 4'hF;
    bus_off = 1'b0;
    {n_fail, tests_run, cycles} = '0;
    f = '0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    rchk(`CMB_IEN_OFS, 32'h0, 32'hFFFFFFFF);
    rchk(`CMB_MAILBOX_INTERRUPT_FLAGS_OFS, 32'h0, 32'hFFFFFFFF);
    rchk(12'h040, 32'h0, 32'hFFFFFFFF);
    // Inactive mailbox 0 and active mailbox 1 share the id
    bus(1'b1, mb(0, 1), {3'h0, ID_A});
    bus(1'b1, mb(1, 0), cs(CODE_RX_OFF, 4'h0));
    bus(1'b1, mb(1, 1), {3'h0, ID_A});
    bus(1'b1, mb(1, 0), cs(CODE_RX_EMPTY, 4'h0));
    bus(1'b1, `CMB_RXMASK_OFS, 32'h1FFBFFFF);
    bus(1'b1, `CMB_IEN_OFS, 32'h2);
    f.id = ID_A | 29'h00040000;
    f.len = 4'h8;
    f.data = 64'h1122334455667788;
    i_cmb_partner.frame(f, 1'b0, 1'b0);
    repeat (4) @(posedge core_clk);
    chk({31'h0, mb_irq}, 32'h1);
    rchk(`CMB_MAILBOX_INTERRUPT_FLAGS_OFS, 32'h2, 32'hFFFFFFFF);
    rchk(mb(1, 0), cs(CODE_RX_FULL, 4'h8), 32'hFFFF0000);
    rchk(mb(1, 1), {3'h0, f.id}, 32'hFFFFFFFF);
    rchk(mb(1, 2), 32'h11223344, 32'hFFFFFFFF);
    rchk(mb(1, 3), 32'h55667788, 32'hFFFFFFFF);
    bus(1'b0, `CMB_TIMER_OFS, 32'h0);
    // Enable gating of the request
    bus(1'b1, `CMB_IEN_OFS, 32'h0);
    repeat (3) @(posedge core_clk);
    chk({31'h0, mb_irq}, 32'h0);
    bus(1'b1, `CMB_IEN_OFS, 32'h2);
    repeat (3) @(posedge core_clk);
    chk({31'h0, mb_irq}, 32'h1);
    bus(1'b1, `CMB_MAILBOX_INTERRUPT_FLAGS_OFS, 32'h0);
    rchk(`CMB_MAILBOX_INTERRUPT_FLAGS_OFS, 32'h2, 32'hFFFFFFFF);
    bus(1'b1, `CMB_MAILBOX_INTERRUPT_FLAGS_OFS, 32'h2);
    rchk(`CMB_MAILBOX_INTERRUPT_FLAGS_OFS, 32'h0, 32'hFFFFFFFF);
    chk({31'h0, mb_irq}, 32'h0);
    // Errored frame is dropped
    i_cmb_partner.frame(f, 1'b0, 1'b1);
    repeat (4) @(posedge core_clk);
    rchk(`CMB_MAILBOX_INTERRUPT_FLAGS_OFS, 32'h0, 32'hFFFFFFFF);
    // Locked mailbox holds off the move-in until unlocked
    rchk(mb(1, 0), cs(CODE_RX_FULL, 4'h8), 32'hFFFF0000);
    f.data = 64'hA5A5A5A55A5A5A5A;
    i_cmb_partner.frame(f, 1'b0, 1'b0);
    repeat (4) @(posedge core_clk);
    rchk(`CMB_MAILBOX_INTERRUPT_FLAGS_OFS, 32'h0, 32'hFFFFFFFF);
    bus(1'b0, `CMB_TIMER_OFS, 32'h0);
    repeat (4) @(posedge core_clk);
    rchk(`CMB_MAILBOX_INTERRUPT_FLAGS_OFS, 32'h2, 32'hFFFFFFFF);
    rchk(mb(1, 2), 32'hA5A5A5A5, 32'hFFFFFFFF);
    bus(1'b1, `CMB_MAILBOX_INTERRUPT_FLAGS_OFS, 32'h2);
    // Two transmit mailboxes prepared while frozen, lowest id wins
    bus(1'b1, `CMB_CTRL_OFS, 32'h1);
    bus(1'b1, mb(2, 0), cs(CODE_TX_OFF, 4'h0));
    bus(1'b1, mb(2, 1), {3'h0, ID_B});
    bus(1'b1, mb(2, 2), 32'hCAFEF00D);
    bus(1'b1, mb(2, 0), cs(4'hC, 4'hF));
    bus(1'b1, mb(3, 0), cs(CODE_TX_OFF, 4'h0));
    bus(1'b1, mb(3, 1), {3'h0, ID_A});
    bus(1'b1, mb(3, 0), cs(4'hC, 4'h4));
    bus(1'b1, `CMB_CTRL_OFS, 32'h0);
    for (int i = 0; i < 40 && tx_pending !== 1'b1; i++) @(negedge core_clk);
    chk({31'h0, tx_pending}, 32'h1);
    chk({3'h0, tx_frame.id}, {3'h0, ID_A});
    i_cmb_partner.frame(f, 1'b1, 1'b0);
    repeat (4) @(posedge core_clk);
    rchk(`CMB_MAILBOX_INTERRUPT_FLAGS_OFS, 32'hA, 32'hFFFFFFFF);
    rchk(mb(3, 0), cs(CODE_TX_OFF, 4'h4), 32'hFFFF0000);
    rchk(mb(1, 1), {3'h0, ID_A}, 32'hFFFFFFFF);
    // Lowest mailbox number wins; length capped at eight bytes
    bus(1'b1, `CMB_CTRL_OFS, 32'h11);
    bus(1'b1, mb(3, 0), cs(CODE_TX_OFF, 4'h0));
    bus(1'b1, mb(3, 0), cs(4'hC, 4'h4));
    bus(1'b1, `CMB_CTRL_OFS, 32'h10);
    for (int i = 0; i < 40 && tx_pending !== 1'b1; i++) @(negedge core_clk);
    chk({3'h0, tx_frame.id}, {3'h0, ID_B});
    chk({28'h0, tx_frame.nbytes}, 32'h8);
    chk(tx_frame.data[63:32], 32'hCAFEF00D);
    close_out();
  end
endmodule
